// file: rtl/rsc_defs.vh
// How it works
// RULE_01: Select bit 0: pin is plain input, external reset held inactive.
// RULE_02: Select bit 1: pin is active-low reset input with weak pull-up.
// RULE_03: Power-up timer disable bit 1 disables timer, 0 enables it.
// RULE_04: Watchdog enable bit 1 enables watchdog, 0 disables it.
// RULE_05: Three-bit oscillator select decodes eight clock modes.
// RULE_06: External reset in internal or RC modes stops internal oscillator.
// RULE_07: Six reset causes are distinguished and reported.
// RULE_08: Reset-independent registers keep contents through every non power-on reset.
// RULE_09: Ordinary registers reset on power-on, pin, watchdog and brown-out resets.
// RULE_10: Watchdog wake-up from sleep does not reset ordinary registers.
// RULE_11: Time-out and power-down flags set per reset or wake-up cause.
// RULE_12: External reset input filtered so short pulses are ignored.
// RULE_13: Watchdog reset never drives the external reset pin low.
// RULE_14: Chip held in reset until supply detector reports power good.
// RULE_15: Power-on reset fires only on fresh power-up, not falling supply.
// RULE_16: With brown-out enabled, reset held until supply above threshold.
// RULE_17: After release, enabled power-up timer holds reset further 64 ms.
// RULE_18: Power-up timer starts after power-on; start-up timer after it.
// RULE_19: Power-on flag bit 1 reads 0 after power-on; software sets it.
// RULE_20: Brown-out flag bit 0 cleared by brown-out reset after software set.
// RULE_21: Combined reset deassertion synchronised to the system clock.
// RULE_22: Pin filter counts low samples before asserting reset.
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_OSC_EXT_RC_CLKOUT 3'h7
`define RSC_OSC_EXT_RC_IO 3'h6
`define RSC_OSC_INTERNAL_CLKOUT 3'h5
`define RSC_OSC_INTERNAL_IO 3'h4
`define RSC_OSC_EXT_CLOCK_IN 3'h3
`define RSC_OSC_HIGH_SPEED 3'h2
`define RSC_OSC_STD_CRYSTAL 3'h1
`define RSC_OSC_LOW_POWER 3'h0
`define RSC_PWRC_BROWNOUT_BIT 0
`define RSC_PWRC_POWERON_BIT 1
`define RSC_CAUSE_NONE 3'h0
`define RSC_CAUSE_POWERON 3'h1
`define RSC_CAUSE_WDT_RUN 3'h2
`define RSC_CAUSE_WDT_SLEEP 3'h3
`define RSC_CAUSE_PIN_RUN 3'h4
`define RSC_CAUSE_PIN_SLEEP 3'h5
`define RSC_CAUSE_BROWNOUT 3'h6
`define RSC_CAUSE_WDT_WAKE 3'h7
`define RSC_CLK_PERIOD_NS 10
`define RSC_POWERUP_TIMER_MS 64
`define RSC_POWERUP_TIMER_CYCLES ((`RSC_POWERUP_TIMER_MS * 1000000) / `RSC_CLK_PERIOD_NS)
`define RSC_OST_CYCLES 1024
`define RSC_FILT_CYCLES 16
`define RSC_SYNC_STAGES 2
`endif

// file: rtl/rsc_reset_source_config.v
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"
module rsc_reset_source_config #(
  parameter POWERUP_TIMER_CYCLES = `RSC_POWERUP_TIMER_CYCLES,
  parameter OST_CYCLES = `RSC_OST_CYCLES,
  parameter FILT_CYCLES = `RSC_FILT_CYCLES,
  parameter HOLD_W = 23
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Configuration word fields
  input wire ext_reset_pin_select,
  input wire powerup_timer_disable,
  input wire watchdog_enable,
  input wire [2:0] osc_select,
  input wire brownout_enable,
  // Supply monitors
  input wire supply_power_good,
  input wire supply_above_brownout,
  input wire supply_at_ground,
  // Pin and core events
  input wire port_a3_reset_pin_in,
  input wire watchdog_timeout,
  input wire core_sleeping,
  // Software access to power control register
  input wire pwrc_wr,
  input wire [1:0] pwrc_wdata,
  // Outputs
  output reg core_reset_r,
  output reg retained_reset_r,
  output reg port_a3_pullup_en_r,
  output reg port_a3_oe_r,
  output reg port_a3_digital_in_r,
  output reg internal_osc_stop_r,
  output reg watchdog_run_r,
  output reg [2:0] osc_mode_r,
  output reg osc_is_crystal_r,
  output reg clkout_en_r,
  output reg timeout_flag_r,
  output reg powerdown_flag_r,
  output reg [1:0] power_control_reg_r,
  output reg [2:0] reset_cause_r,
  output reg powerup_timer_active_r,
  output reg osc_startup_active_r
);
  localparam ST_HOLD = 3'h0;
  localparam ST_POWERUP_TIMER = 3'h1;
  localparam ST_OST = 3'h2;
  localparam ST_RUN = 3'h3;
  localparam ST_PINHOLD = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [HOLD_W-1:0] cnt_r;
  reg [HOLD_W-1:0] cnt_nxt;
  reg [7:0] filt_r;
  reg pin_reset_r;
  reg por_armed_r;
  reg por_event_r;
  reg powered_r;
  reg bor_event_r;
  reg [`RSC_SYNC_STAGES-1:0] rel_sync_r;
  reg cold_r;
  reg osc_internal_or_rc;
  reg osc_crystal;
  reg osc_clkout;

  // Pin function: with select low the reset input is held inactive
  wire pin_level = ext_reset_pin_select ? port_a3_reset_pin_in : 1'b1; // [RULE_01] [RULE_02]
  wire bor_low = brownout_enable & ~supply_above_brownout;
  // A falling supply resets only once it reaches ground; otherwise only brown-out or a fresh power-up can
  wire hold_req = ~powered_r | bor_low; // [RULE_14] [RULE_15] [RULE_16]
  wire wdt_evt = watchdog_run_r & watchdog_timeout;
  wire busy = (state_r != ST_RUN);

  // Oscillator mode decode
  always @* begin
    osc_crystal = 1'b0;
    osc_clkout = 1'b0;
    osc_internal_or_rc = 1'b0;
    case (osc_select) // [RULE_05]
      `RSC_OSC_EXT_RC_CLKOUT: begin
        osc_internal_or_rc = 1'b1;
        osc_clkout = 1'b1;
      end
      `RSC_OSC_EXT_RC_IO: begin
        osc_internal_or_rc = 1'b1;
      end
      `RSC_OSC_INTERNAL_CLKOUT: begin
        osc_internal_or_rc = 1'b1;
        osc_clkout = 1'b1;
      end
      `RSC_OSC_INTERNAL_IO: begin
        osc_internal_or_rc = 1'b1;
      end
      `RSC_OSC_EXT_CLOCK_IN: begin
        osc_clkout = 1'b0;
      end
      `RSC_OSC_HIGH_SPEED, `RSC_OSC_STD_CRYSTAL, `RSC_OSC_LOW_POWER: begin
        osc_crystal = 1'b1;
      end
      default: begin
        osc_crystal = 1'b0;
      end
    endcase
  end

  // Filter: low must persist FILT_CYCLES samples before pin reset asserts
  always @(posedge mclk) begin
    if (reset) begin
      filt_r <= 8'h00;
      pin_reset_r <= 1'b0;
    end else if (pin_level) begin
      filt_r <= 8'h00; // [RULE_12]
      pin_reset_r <= 1'b0;
    end else if (filt_r >= FILT_CYCLES[7:0] - 8'h01) begin
      pin_reset_r <= 1'b1; // [RULE_22]
    end else begin
      filt_r <= filt_r + 8'h01;
    end
  end

  // Power-on detector re-arms only after supply returns to ground
  always @(posedge mclk) begin
    if (reset) begin
      por_armed_r <= 1'b1;
      por_event_r <= 1'b0;
      powered_r <= 1'b0;
      bor_event_r <= 1'b0;
    end else begin
      por_event_r <= 1'b0;
      bor_event_r <= (state_r == ST_RUN) & bor_low;
      if (supply_at_ground) begin
        por_armed_r <= 1'b1; // [RULE_15]
        powered_r <= 1'b0;
      end else if (por_armed_r && supply_power_good) begin
        por_armed_r <= 1'b0;
        por_event_r <= 1'b1;
        powered_r <= 1'b1;
      end
    end
  end

  // Reset sequence
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_HOLD: begin
        cnt_nxt = {HOLD_W{1'b0}};
        if (!hold_req) begin
          if (!powerup_timer_disable) begin
            state_nxt = ST_POWERUP_TIMER; // [RULE_03] [RULE_17]
          end else if (osc_crystal && cold_r) begin
            state_nxt = ST_OST;
          end else begin
            state_nxt = ST_PINHOLD;
          end
        end
      end
      ST_POWERUP_TIMER: begin
        cnt_nxt = cnt_r + {{(HOLD_W-1){1'b0}}, 1'b1};
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end else if (cnt_r >= POWERUP_TIMER_CYCLES[HOLD_W-1:0] - {{(HOLD_W-1){1'b0}}, 1'b1}) begin
          cnt_nxt = {HOLD_W{1'b0}};
          state_nxt = (osc_crystal && cold_r) ? ST_OST : ST_PINHOLD; // [RULE_18]
        end
      end
      ST_OST: begin
        cnt_nxt = cnt_r + {{(HOLD_W-1){1'b0}}, 1'b1};
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end else if (cnt_r >= OST_CYCLES[HOLD_W-1:0] - {{(HOLD_W-1){1'b0}}, 1'b1}) begin
          state_nxt = ST_PINHOLD;
        end
      end
      ST_PINHOLD: begin
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end else if (!pin_reset_r) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hold_req || pin_reset_r || (wdt_evt && !core_sleeping)) begin
          state_nxt = ST_HOLD; // [RULE_09]
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_HOLD;
      cnt_r <= {HOLD_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Start-up timer runs only after a cold start; release passes a two-flop chain
  always @(posedge mclk) begin
    if (reset) begin
      cold_r <= 1'b1;
      rel_sync_r <= {`RSC_SYNC_STAGES{1'b0}};
    end else begin
      if (por_event_r || bor_event_r) begin
        cold_r <= 1'b1;
      end else if (state_r == ST_RUN) begin
        cold_r <= 1'b0;
      end
      rel_sync_r <= {rel_sync_r[`RSC_SYNC_STAGES-2:0], (state_r == ST_RUN)}; // [RULE_21]
    end
  end

  // Cause capture and status flags
  always @(posedge mclk) begin
    if (reset) begin
      reset_cause_r <= `RSC_CAUSE_NONE;
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b1;
    end else begin
      if (por_event_r) begin
        reset_cause_r <= `RSC_CAUSE_POWERON; // [RULE_07]
        timeout_flag_r <= 1'b1; // [RULE_11]
        powerdown_flag_r <= 1'b1;
      end else if (bor_event_r) begin
        reset_cause_r <= `RSC_CAUSE_BROWNOUT;
        timeout_flag_r <= 1'b1;
        powerdown_flag_r <= 1'b1;
      end else if (state_r == ST_RUN && wdt_evt) begin
        reset_cause_r <= core_sleeping ? `RSC_CAUSE_WDT_WAKE : `RSC_CAUSE_WDT_RUN;
        timeout_flag_r <= 1'b0;
        if (core_sleeping) begin
          powerdown_flag_r <= 1'b0;
        end
      end else if (state_r == ST_RUN && pin_reset_r) begin
        reset_cause_r <= core_sleeping ? `RSC_CAUSE_PIN_SLEEP : `RSC_CAUSE_PIN_RUN;
        if (core_sleeping) begin
          timeout_flag_r <= 1'b1;
          powerdown_flag_r <= 1'b0;
        end
      end
    end
  end

  // Power control register: a hardware clear beats a software write in one cycle
  always @(posedge mclk) begin
    if (reset) begin
      power_control_reg_r <= 2'b00;
    end else begin
      if (pwrc_wr) begin
        power_control_reg_r <= pwrc_wdata;
      end
      if (por_event_r) begin
        power_control_reg_r[`RSC_PWRC_POWERON_BIT] <= 1'b0; // [RULE_19]
      end else if (bor_event_r) begin
        power_control_reg_r[`RSC_PWRC_BROWNOUT_BIT] <= 1'b0; // [RULE_20]
      end
    end
  end

  // Reset and sequencer outputs
  always @(posedge mclk) begin
    if (reset) begin
      core_reset_r <= 1'b1;
      retained_reset_r <= 1'b1;
      internal_osc_stop_r <= 1'b0;
      watchdog_run_r <= 1'b0;
      powerup_timer_active_r <= 1'b0;
      osc_startup_active_r <= 1'b0;
    end else begin
      core_reset_r <= ~rel_sync_r[`RSC_SYNC_STAGES-1] | (state_r != ST_RUN); // [RULE_10]
      retained_reset_r <= por_event_r | ~powered_r; // [RULE_08]
      internal_osc_stop_r <= pin_reset_r & osc_internal_or_rc; // [RULE_06]
      watchdog_run_r <= watchdog_enable & ~busy; // [RULE_04]
      powerup_timer_active_r <= (state_nxt == ST_POWERUP_TIMER);
      osc_startup_active_r <= (state_nxt == ST_OST);
    end
  end

  // Pin function and oscillator configuration outputs
  always @(posedge mclk) begin
    if (reset) begin
      port_a3_pullup_en_r <= 1'b0;
      port_a3_oe_r <= 1'b0;
      port_a3_digital_in_r <= 1'b1;
      osc_mode_r <= `RSC_OSC_LOW_POWER;
      osc_is_crystal_r <= 1'b1;
      clkout_en_r <= 1'b0;
    end else begin
      port_a3_pullup_en_r <= ext_reset_pin_select; // [RULE_02]
      port_a3_oe_r <= 1'b0; // [RULE_13]
      port_a3_digital_in_r <= ~ext_reset_pin_select; // [RULE_01]
      osc_mode_r <= osc_select; // [RULE_05]
      osc_is_crystal_r <= osc_crystal;
      clkout_en_r <= osc_clkout;
    end
  end
endmodule // rsc_reset_source_config
`default_nettype wire

// file: verif/rsc_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_far_side (
  // Commands from the bench
  input wire logic pin_low,
  input wire logic pull_on,
  input wire logic [2:0] supply,
  // Lines into the block
  output logic pin,
  output logic power_good,
  output logic above_bo,
  output logic at_ground
);
  // Released pin floats to the pull-up level only when it is enabled
  assign pin = pin_low ? 1'b0 : pull_on;
  assign power_good = supply[0];
  assign above_bo = supply[1];
  assign at_ground = supply[2];
endmodule // rsc_far_side
`default_nettype wire

// file: verif/rsc_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched inputs
  input wire logic ext_reset_pin_select,
  input wire logic watchdog_enable,
  input wire logic [2:0] osc_select,
  input wire logic port_a3_reset_pin_in,
  // Watched outputs
  input wire logic core_reset_r,
  input wire logic port_a3_pullup_en_r,
  input wire logic port_a3_oe_r,
  input wire logic port_a3_digital_in_r,
  input wire logic internal_osc_stop_r,
  input wire logic watchdog_run_r,
  input wire logic [2:0] osc_mode_r,
  input wire logic osc_is_crystal_r,
  input wire logic clkout_en_r,
  input wire logic powerup_timer_active_r,
  input wire logic osc_startup_active_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_oe; !port_a3_oe_r; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  property p_pull; ext_reset_pin_select ##1 ext_reset_pin_select |-> port_a3_pullup_en_r; endproperty
  a_pull: assert property (p_pull) else $error("no pull-up");
  property p_dig; !ext_reset_pin_select ##1 !ext_reset_pin_select |-> port_a3_digital_in_r; endproperty
  a_dig: assert property (p_dig) else $error("pin not digital");
  property p_osc;
    !$past(reset) |-> osc_mode_r == $past(osc_select) && osc_is_crystal_r == ($past(osc_select) < 3'h3)
      && clkout_en_r == ($past(osc_select) == 3'h7 || $past(osc_select) == 3'h5);
  endproperty
  a_osc: assert property (p_osc) else $error("mode decode wrong");
  property p_wdt; !watchdog_enable |=> !watchdog_run_r; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog runs");
  property p_powerup_timer; $rose(powerup_timer_active_r) |-> (powerup_timer_active_r && core_reset_r)[*8]; endproperty
  a_powerup_timer: assert property (p_powerup_timer) else $error("timer hold short");
  property p_seq; osc_startup_active_r |-> !powerup_timer_active_r && core_reset_r; endproperty
  a_seq: assert property (p_seq) else $error("timer overlap");
  property p_filt;
    $rose(internal_osc_stop_r) |-> !$past(port_a3_reset_pin_in, 2) && !$past(port_a3_reset_pin_in, 3)
      && !$past(port_a3_reset_pin_in, 4);
  endproperty
  a_filt: assert property (p_filt) else $error("short pulse taken");
  property p_rel; $fell(core_reset_r) |-> !$past(powerup_timer_active_r, 2) && !$past(osc_startup_active_r, 2);
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  c_powerup_timer: cover property ($rose(powerup_timer_active_r));
  c_ost: cover property ($rose(osc_startup_active_r));
  c_stop: cover property ($rose(internal_osc_stop_r));
  c_rel: cover property ($fell(core_reset_r));
endmodule // rsc_checker
bind rsc_reset_source_config rsc_checker u_chk (.mclk, .reset, .ext_reset_pin_select, .watchdog_enable,
  .osc_select, .port_a3_reset_pin_in, .core_reset_r, .port_a3_pullup_en_r, .port_a3_oe_r, .port_a3_digital_in_r,
  .internal_osc_stop_r, .watchdog_run_r, .osc_mode_r, .osc_is_crystal_r, .clkout_en_r, .powerup_timer_active_r,
  .osc_startup_active_r);
`default_nettype wire

// file: verif/rsc_reset_source_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_source_config_tb;
  logic mclk, reset, sel, ptd, wde, boe, wdt, slp, wr, pin_low;
  logic [2:0] osc;
  logic [1:0] wdata;
  logic [2:0] supply;
  wire pin, pg, abo, agnd, crst, rrst, pull, oe, din, ostop, wrun, xtal, ckout, to_f, pd_f, pta, osa;
  wire [2:0] mode, cause;
  wire [1:0] power_control_reg;
  integer fail_count, checks, cyc, n, i;
  rsc_far_side far (.pin_low(pin_low), .pull_on(sel), .supply(supply), .pin(pin), .power_good(pg), .above_bo(abo),
    .at_ground(agnd));
  rsc_reset_source_config #(.POWERUP_TIMER_CYCLES(50), .OST_CYCLES(8), .FILT_CYCLES(4)) dut (.mclk(mclk), .reset(reset),
    .ext_reset_pin_select(sel), .powerup_timer_disable(ptd), .watchdog_enable(wde), .osc_select(osc),
    .brownout_enable(boe), .supply_power_good(pg), .supply_above_brownout(abo), .supply_at_ground(agnd),
    .port_a3_reset_pin_in(pin), .watchdog_timeout(wdt), .core_sleeping(slp), .pwrc_wr(wr), .pwrc_wdata(wdata),
    .core_reset_r(crst), .retained_reset_r(rrst), .port_a3_pullup_en_r(pull), .port_a3_oe_r(oe),
    .port_a3_digital_in_r(din), .internal_osc_stop_r(ostop), .watchdog_run_r(wrun), .osc_mode_r(mode),
    .osc_is_crystal_r(xtal), .clkout_en_r(ckout), .timeout_flag_r(to_f), .powerdown_flag_r(pd_f),
    .power_control_reg_r(power_control_reg), .reset_cause_r(cause), .powerup_timer_active_r(pta), .osc_startup_active_r(osa));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input integer k);
    repeat (k) @(negedge mclk);
  endtask
  // Bounded wait for the core to leave reset, returns cycles taken
  task wait_rel(output integer c);
    c = 0;
    while (crst !== 1'b0 && c < 500) begin
      step(1);
      c = c + 1;
    end
    chk(c < 500, 1);
  endtask
  task pulse_wdt;
    wdt = 1'b1;
    step(1);
    wdt = 1'b0;
    step(3);
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial begin
    {fail_count, checks, cyc} = 0;
    {reset, sel} = 2'h3;
    {ptd, wde, boe, wdt, slp, wr, pin_low} = 7'h00;
    osc = 3'h1;
    {wdata, supply} = 5'h00;
    step(20);
    reset = 1'b0;
    step(10);
    chk(crst, 1);
    supply = 2'h3;
    wait_rel(n);
    chk(n >= 58 && n < 80, 1);
    chk(cause, 1);
    chk(power_control_reg[1], 0);
    chk({to_f, pd_f}, 3);
    $display("test power-up done");
    for (i = 0; i < 8; i = i + 1) begin
      osc = i;
      step(2);
      chk({xtal, mode}, {i < 3, i[2:0]});
      chk(ckout, i == 7 || i == 5);
    end
    osc = 3'h4;
    {wr, wdata} = 3'h7;
    step(1);
    wr = 1'b0;
    step(1);
    chk(power_control_reg, 3);
    supply = 2'h2;
    step(10);
    chk(crst, 0);
    supply = 2'h3;
    pin_low = 1'b1;
    step(3);
    pin_low = 1'b0;
    step(6);
    chk(crst, 0);
    pin_low = 1'b1;
    step(10);
    chk({ostop, crst, pull}, 7);
    pin_low = 1'b0;
    wait_rel(n);
    chk({rrst, cause}, 4);
    chk({power_control_reg, to_f, pd_f}, 15);
    $display("test pin reset done");
    wde = 1'b1;
    step(3);
    chk(wrun, 1);
    pulse_wdt;
    chk({crst, oe}, 2);
    wait_rel(n);
    chk({to_f, cause}, 2);
    slp = 1'b1;
    step(2);
    pulse_wdt;
    chk(crst, 0);
    chk({to_f, pd_f, cause}, 7);
    {slp, wde} = 2'h0;
    step(2);
    chk(wrun, 0);
    $display("test watchdog done");
    boe = 1'b1;
    supply = 2'h1;
    step(100);
    chk({crst, cause}, 14);
    chk(power_control_reg[0], 0);
    supply = 2'h3;
    wait_rel(n);
    chk({to_f, pd_f}, 3);
    $display("test brown-out done");
    supply = 3'h4;
    step(5);
    chk({rrst, crst}, 3);
    supply = 3'h3;
    wait_rel(n);
    chk({power_control_reg[1], cause}, 1);
    chk({rrst, to_f, pd_f}, 3);
    $display("test power re-arm done");
    ptd = 1'b1;
    slp = 1'b1;
    pin_low = 1'b1;
    step(10);
    chk({to_f, pd_f, cause}, 8'h15);
    pin_low = 1'b0;
    slp = 1'b0;
    wait_rel(n);
    chk(n < 20, 1);
    sel = 1'b0;
    step(2);
    chk({din, pull}, 2);
    pin_low = 1'b1;
    step(10);
    chk(crst, 0);
    pin_low = 1'b0;
    $display("test pin select done");
    wrap_up;
  end
endmodule // rsc_reset_source_config_tb
`default_nettype wire
